// ### src/dcs_pkg.sv
// shared constants and types for the drive command/status profile block
// assumes one system clock; all users reference items as dcs_pkg::name
package dcs_pkg;

	// ==================================================================
	// word layout
	localparam int unsigned WORD_W = 16;  // command, status, ref width
	localparam int unsigned FREQ_W = 16;  // drive-side frequency width
	localparam int unsigned FRAC_SH = 14; // 16384 is full scale
	localparam int unsigned MAG_W = 15;   // magnitude part of a word
	localparam logic [14:0] MAG_MAX = 15'h7fff; // 200 percent
	localparam logic [16:0] SREF_MAX = 17'h07fff; // +32767
	localparam logic [16:0] SREF_MIN = 17'h18001; // -32767

	// command word bit positions
	localparam int unsigned CW_ON1 = 0;
	localparam int unsigned CW_ON2 = 1;
	localparam int unsigned CW_ON3 = 2;
	localparam int unsigned CW_COAST = 3;
	localparam int unsigned CW_RESET = 7;
	localparam int unsigned CW_JOG1 = 8;
	localparam int unsigned CW_JOG2 = 9;
	localparam int unsigned CW_VALID = 10;
	localparam int unsigned CW_SLOW = 11;
	localparam int unsigned CW_CATCH = 12;

	// state word reset value: coast_off_cmd/quick_off_cmd shown, start disabled
	localparam logic [15:0] SW_RST = 16'h0070;
	localparam logic [15:0] CW_RST = 16'h0000;

	// ==================================================================
	// node address and line speed
	localparam logic [7:0] ADDR_DEF = 8'h01;
	localparam logic [7:0] ADDR_MIN_NAT = 8'h00;
	localparam logic [7:0] ADDR_MIN_BUS = 8'h01;
	localparam logic [7:0] ADDR_MAX_STD = 8'hf7; // 247
	localparam logic [7:0] ADDR_MAX_BLD = 8'hff; // 255

	typedef enum logic [2:0] {
		DCS_BD_300 = 3'h0,
		DCS_BD_600 = 3'h1,
		DCS_BD_1200 = 3'h2,
		DCS_BD_2400 = 3'h3,
		DCS_BD_4800 = 3'h4,
		DCS_BD_9600 = 3'h5
	} dcs_baud_t;

	typedef enum logic [1:0] {
		DCS_PR_NATIVE = 2'h0,
		DCS_PR_BLDG = 2'h1,
		DCS_PR_MODBUS = 2'h3
	} dcs_proto_t;

	// command source selector codes
	typedef enum logic [1:0] {
		DCS_SRC_DIN = 2'h0,
		DCS_SRC_SER = 2'h1,
		DCS_SRC_AND = 2'h2,
		DCS_SRC_OR = 2'h3
	} dcs_src_t;

	// start-disable machine, one-hot
	typedef enum logic [1:0] {
		DCS_SD_LOCK = 2'b01,
		DCS_SD_FREE = 2'b10
	} dcs_sd_t;

	// ==================================================================
	// carriers
	typedef struct packed {
		logic drive_ready;
		logic trip;
		logic warning;
		logic at_ref;
		logic serial_ok;
		logic freq_ok;
		logic running;
		logic volt_warn;
		logic cur_limit;
		logic therm_warn;
	} dcs_drv_st_t;

	typedef struct packed {
		logic wr;        // one-cycle local panel store
		logic [7:0] addr;
		dcs_baud_t baud;
		dcs_src_t coast_sel;
	} dcs_local_cfg_t;

	typedef struct packed {
		logic [15:0] cw;
		logic [15:0] sref;
		dcs_sd_t sd;
		logic [15:0] sw;
		logic [15:0] fword;
		logic [15:0] target;
		logic rev;
		logic coast;
		logic trst;
		logic [7:0] addr;
		dcs_baud_t baud;
		dcs_src_t csel;
		logic rej;
	} dcs_state_t;

endpackage : dcs_pkg

// ### src/dcs_src_sel.sv
// combines a digital input with a serial command per source selector
// assumes both inputs mean 1 = function released (active-low command)
`timescale 1ns/1ps
`default_nettype none

module dcs_src_sel (
	// selector
	input wire dcs_pkg::dcs_src_t sel,
	// run levels from both sources
	input wire logic din_run,
	input wire logic ser_run,
	// result
	output logic run
);

	// ==================================================================
	// selection
	always_comb begin
		case (sel)
			dcs_pkg::DCS_SRC_DIN: run = din_run;
			dcs_pkg::DCS_SRC_SER: run = ser_run;
			dcs_pkg::DCS_SRC_AND: run = din_run | ser_run;
			dcs_pkg::DCS_SRC_OR: run = din_run & ser_run;
			default: run = din_run & ser_run;
		endcase
	end

endmodule : dcs_src_sel

`default_nettype wire

// ### src/dcs_span_map.sv
// maps a 0..16384 magnitude linearly onto lo..hi, saturating
// assumes hi >= lo; above 16384 the line is extended up to 200 percent
`timescale 1ns/1ps
`default_nettype none

module dcs_span_map #(
	parameter int unsigned W = dcs_pkg::FREQ_W
) (
	// magnitude and span
	input wire logic [dcs_pkg::MAG_W-1:0] mag,
	input wire logic [W-1:0] lo,
	input wire logic [W-1:0] hi,
	// mapped value
	output logic [W-1:0] val
);

	logic [W-1:0] span;                     // hi minus lo
	logic [W+dcs_pkg::MAG_W-1:0] prod;      // mag times span
	logic [W+dcs_pkg::MAG_W-1:0] sum;       // lo plus scaled

	// ==================================================================
	// scale, offset, clip
	always_comb begin
		span = (hi > lo) ? (hi - lo) : '0;
		prod = W'(mag) * (W+dcs_pkg::MAG_W)'(span);
		sum = (prod >> dcs_pkg::FRAC_SH) + (W+dcs_pkg::MAG_W)'(lo);
		// clip instead of wrap when 200 percent overshoots
		val = (sum[W+dcs_pkg::MAG_W-1:W] != '0) ? '1 : sum[W-1:0];
	end

endmodule : dcs_span_map

`default_nettype wire

// ### src/dcs_core.sv
// command interpreter for the fieldbus drive profile: command word in,
// state word and output-frequency word out, reference scaling, coast
// source selection and node settings.
// assumes serial frames are already decoded into one-cycle strobes.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - bit 08 selects bus jog one
// - bit 09 selects bus jog two
// - bit 11 lowers reference by amount
// - bit 12 raises reference by amount
// - both set: slow-down wins
// - state bit 00 needs on1-3, ready
// - state bit 02 needs bits 00-03, no trip
// - state bits 04/05 invert command 01/02
// - start-disable set on reset, off, power
// - clear start-disable via 0 with 01,02,10
// - state word bits report drive flags
// - reference signed, 16384 is 100 percent
// - reference 0..16384 spans min..max
// - negative reference reverses rotation
// - frequency word signed, 16384 full span
// - frequency word spans low..high limit
// - address range by protocol, default one
// - serial writes of address/speed rejected
// - line speed codes 0-5, default 9600
// - coast source codes 0-3, default or
// - serial source: serial command only
// - and source: both sources needed
// - coast commands active low
// - bit 10 low ignores command word
// - trip reset on rising bit 07
module dcs_core (
	// clock, reset, enable
	input wire logic clock,
	input wire logic reset,
	input wire logic ce,
	// serial side, one-cycle strobes
	input wire logic cmd_wr,
	input wire logic [15:0] cmd_word,
	input wire logic ref_wr,
	input wire logic [15:0] ref_word,
	input wire logic cfg_wr_serial,
	// local control unit
	input wire dcs_pkg::dcs_local_cfg_t local_cfg,
	input wire dcs_pkg::dcs_proto_t proto,
	// drive condition
	input wire dcs_pkg::dcs_drv_st_t drv,
	input wire logic coast_in_n,
	input wire logic [dcs_pkg::FREQ_W-1:0] freq_now,
	input wire logic freq_rev,
	// drive settings
	input wire logic [dcs_pkg::FREQ_W-1:0] ref_min,
	input wire logic [dcs_pkg::FREQ_W-1:0] ref_max,
	input wire logic [dcs_pkg::FREQ_W-1:0] flim_lo,
	input wire logic [dcs_pkg::FREQ_W-1:0] flim_hi,
	input wire logic [15:0] catch_amt,
	input wire logic [dcs_pkg::FREQ_W-1:0] jog1_freq,
	input wire logic [dcs_pkg::FREQ_W-1:0] jog2_freq,
	// answers to the master
	output logic [15:0] status_word,
	output logic [15:0] freq_word,
	output logic cfg_rejected,
	// drive commands
	output logic [15:0] applied_cmd,
	output logic [dcs_pkg::FREQ_W-1:0] target_freq,
	output logic reverse,
	output logic coast_active,
	output logic trip_reset,
	// node settings
	output logic [7:0] node_addr,
	output var dcs_pkg::dcs_baud_t line_speed,
	output var dcs_pkg::dcs_src_t coast_sel
);

	localparam int unsigned FW = dcs_pkg::FREQ_W;
	localparam int unsigned NW = FW + dcs_pkg::FRAC_SH; // quotient width

	dcs_pkg::dcs_state_t st_q; // all block state
	dcs_pkg::dcs_state_t st_d; // next state

	logic take;              // accepted command word
	logic [15:0] cw_nx;      // command word after this cycle
	logic set_sd;            // any start-disable setting event
	logic clr_sd;            // start-disable release pattern
	logic [16:0] adj;        // adjusted reference, signed
	logic [16:0] sref_x;     // sign-extended stored reference
	logic [16:0] amt_x;      // zero-extended step amount
	logic [16:0] mag17;      // absolute reference
	logic [dcs_pkg::MAG_W-1:0] ref_mag; // clipped magnitude
	logic [FW-1:0] ref_val;  // scaled reference
	logic run_ok;            // coast source says run
	logic [FW-1:0] fspan;    // frequency limit span
	logic [FW-1:0] fdiff;    // frequency above low limit
	logic [NW-1:0] fnum;     // scaled numerator
	logic [NW-1:0] fquo;     // quotient
	logic [dcs_pkg::MAG_W-1:0] fmag; // clipped frequency magnitude
	logic addr_ok;           // local address within protocol range
	logic [7:0] amin;        // lowest legal address
	logic [7:0] amax;        // highest legal address

	// ==================================================================
	// helpers

	// reference magnitude onto min..max
	dcs_span_map #(
		.W(FW)
	) u_ref_map (
		.mag(ref_mag),
		.lo(ref_min),
		.hi(ref_max),
		.val(ref_val)
	);

	// coast source: both inputs are active low commands
	dcs_src_sel u_coast_sel (
		.sel(st_q.csel),
		.din_run(coast_in_n),
		.ser_run(cw_nx[dcs_pkg::CW_COAST]),
		.run(run_ok)
	);

	// ==================================================================
	// next-state logic
	always_comb begin
		st_d = st_q;
		// pulses last one cycle
		st_d.trst = 1'b0;
		st_d.rej = 1'b0;

		take = cmd_wr & cmd_word[dcs_pkg::CW_VALID];
		cw_nx = take ? cmd_word : st_q.cw;
		st_d.cw = cw_nx;

		st_d.trst = take & cmd_word[dcs_pkg::CW_RESET] & ~st_q.cw[dcs_pkg::CW_RESET];

		set_sd = st_d.trst
			| (st_q.cw[dcs_pkg::CW_ON2] & ~cw_nx[dcs_pkg::CW_ON2])
			| (st_q.cw[dcs_pkg::CW_ON3] & ~cw_nx[dcs_pkg::CW_ON3]);
		// release pattern, only in a freshly accepted word
		// so a held word cannot undo a trip-reset lock a cycle later
		clr_sd = take & ~cw_nx[dcs_pkg::CW_ON1] & cw_nx[dcs_pkg::CW_ON2]
			& cw_nx[dcs_pkg::CW_ON3] & cw_nx[dcs_pkg::CW_VALID];

		// start-disable machine; a setting event beats release
		case (st_q.sd)
			dcs_pkg::DCS_SD_LOCK: begin
				if (clr_sd && !set_sd) begin
					st_d.sd = dcs_pkg::DCS_SD_FREE;
				end
			end
			dcs_pkg::DCS_SD_FREE: begin
				if (set_sd) begin
					st_d.sd = dcs_pkg::DCS_SD_LOCK;
				end
			end
			default: st_d.sd = dcs_pkg::DCS_SD_LOCK;
		endcase

		if (ref_wr) begin
			st_d.sref = ref_word;
		end

		sref_x = {st_q.sref[15], st_q.sref};
		amt_x = {1'b0, catch_amt};
		if (cw_nx[dcs_pkg::CW_SLOW]) begin
			adj = sref_x - amt_x;
		end else if (cw_nx[dcs_pkg::CW_CATCH]) begin
			adj = sref_x + amt_x;
		end else begin
			adj = sref_x;
		end
		// keep within +-32767 so the sign stays meaningful
		if (!adj[16] && adj > dcs_pkg::SREF_MAX) begin
			adj = dcs_pkg::SREF_MAX;
		end else if (adj[16] && adj < dcs_pkg::SREF_MIN) begin
			adj = dcs_pkg::SREF_MIN;
		end

		mag17 = adj[16] ? (17'h00000 - adj) : adj;
		ref_mag = mag17[dcs_pkg::MAG_W-1:0];
		st_d.rev = adj[16];

		if (cw_nx[dcs_pkg::CW_JOG1]) begin
			st_d.target = jog1_freq;
		end else if (cw_nx[dcs_pkg::CW_JOG2]) begin
			st_d.target = jog2_freq;
		end else begin
			st_d.target = ref_val;
		end

		st_d.coast = ~run_ok;

		// state word assembly
		st_d.sw = '0;
		st_d.sw[0] = cw_nx[dcs_pkg::CW_ON1] & cw_nx[dcs_pkg::CW_ON2]
			& cw_nx[dcs_pkg::CW_ON3] & drv.drive_ready;
		// ready while a coast command holds
		st_d.sw[1] = drv.drive_ready & st_d.coast;
		st_d.sw[2] = (&cw_nx[dcs_pkg::CW_COAST:dcs_pkg::CW_ON1]) & ~drv.trip;
		st_d.sw[3] = drv.trip;
		st_d.sw[4] = ~cw_nx[dcs_pkg::CW_ON2];
		st_d.sw[5] = ~cw_nx[dcs_pkg::CW_ON3];
		st_d.sw[6] = (st_d.sd == dcs_pkg::DCS_SD_LOCK);
		st_d.sw[7] = drv.warning;
		st_d.sw[8] = drv.at_ref;
		st_d.sw[9] = drv.serial_ok;
		st_d.sw[10] = drv.freq_ok;
		st_d.sw[11] = drv.running;
		st_d.sw[12] = 1'b0;
		st_d.sw[13] = drv.volt_warn;
		st_d.sw[14] = drv.cur_limit;
		st_d.sw[15] = drv.therm_warn;

		fspan = (flim_hi > flim_lo) ? (flim_hi - flim_lo) : '0;
		fdiff = (freq_now > flim_lo) ? (freq_now - flim_lo) : '0;
		fnum = {fdiff, {dcs_pkg::FRAC_SH{1'b0}}};
		// zero span reports zero rather than dividing by it
		fquo = (fspan == '0) ? '0 : (fnum / NW'(fspan));
		fmag = (fquo > NW'(dcs_pkg::MAG_MAX)) ? dcs_pkg::MAG_MAX : fquo[dcs_pkg::MAG_W-1:0];
		st_d.fword = freq_rev ? (16'h0000 - {1'b0, fmag}) : {1'b0, fmag};

		case (proto)
			dcs_pkg::DCS_PR_NATIVE: begin
				amin = dcs_pkg::ADDR_MIN_NAT;
				amax = dcs_pkg::ADDR_MAX_STD;
			end
			dcs_pkg::DCS_PR_BLDG: begin
				amin = dcs_pkg::ADDR_MIN_BUS;
				amax = dcs_pkg::ADDR_MAX_BLD;
			end
			default: begin
				amin = dcs_pkg::ADDR_MIN_BUS;
				amax = dcs_pkg::ADDR_MAX_STD;
			end
		endcase
		addr_ok = (local_cfg.addr >= amin) && (local_cfg.addr <= amax);

		// settings change only from the local unit
		if (local_cfg.wr) begin
			if (addr_ok) begin
				st_d.addr = local_cfg.addr;
			end
			if (local_cfg.baud <= dcs_pkg::DCS_BD_9600) begin
				st_d.baud = local_cfg.baud;
			end
			st_d.csel = local_cfg.coast_sel;
		end
		st_d.rej = cfg_wr_serial;
	end

	// ==================================================================
	// state register; enable low freezes everything
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			st_q.cw <= dcs_pkg::CW_RST;
			st_q.sref <= '0;
			st_q.sd <= dcs_pkg::DCS_SD_LOCK;
			st_q.sw <= dcs_pkg::SW_RST;
			st_q.fword <= '0;
			st_q.target <= '0;
			st_q.rev <= 1'b0;
			st_q.coast <= 1'b1;
			st_q.trst <= 1'b0;
			st_q.addr <= dcs_pkg::ADDR_DEF;
			st_q.baud <= dcs_pkg::DCS_BD_9600;
			st_q.csel <= dcs_pkg::DCS_SRC_OR;
			st_q.rej <= 1'b0;
		end else if (ce) begin
			st_q <= st_d;
		end
	end

	// ==================================================================
	// outputs, all from the state register
	assign status_word = st_q.sw;
	assign freq_word = st_q.fword;
	assign cfg_rejected = st_q.rej;
	assign applied_cmd = st_q.cw;
	assign target_freq = st_q.target;
	assign reverse = st_q.rev;
	assign coast_active = st_q.coast;
	assign trip_reset = st_q.trst;
	assign node_addr = st_q.addr;
	assign line_speed = st_q.baud;
	assign coast_sel = st_q.csel;

	// ==================================================================
	// checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	// an accepted command word with given bits
	sequence s_take_rise;
		ce && cmd_wr && cmd_word[dcs_pkg::CW_VALID]
			&& cmd_word[dcs_pkg::CW_RESET] && !applied_cmd[dcs_pkg::CW_RESET];
	endsequence

	sequence s_release;
		ce && st_q.sd == dcs_pkg::DCS_SD_LOCK && cmd_wr && cmd_word[dcs_pkg::CW_VALID]
			&& !cmd_word[dcs_pkg::CW_ON1] && cmd_word[dcs_pkg::CW_ON2]
			&& cmd_word[dcs_pkg::CW_ON3] && applied_cmd[dcs_pkg::CW_ON2]
			&& applied_cmd[dcs_pkg::CW_ON3]
			&& !(cmd_word[dcs_pkg::CW_RESET] && !applied_cmd[dcs_pkg::CW_RESET]);
	endsequence

	property p_sw_inv;
		status_word[5:4] == ~applied_cmd[2:1];
	endproperty
	a_sw_inv: assert property (p_sw_inv) else $error("state bits 4/5 not inverse of command");

	property p_coast_rel;
		status_word[2] |-> (&applied_cmd[3:0]);
	endproperty
	a_coast_rel: assert property (p_coast_rel) else $error("coast release without command bits");

	property p_ctl_ready;
		!(&applied_cmd[2:0]) |-> !status_word[0];
	endproperty
	a_ctl_ready: assert property (p_ctl_ready) else $error("control ready with off command");

	property p_bit12;
		status_word[12] == 1'b0;
	endproperty
	a_bit12: assert property (p_bit12) else $error("state bit 12 not zero");

	property p_ignore;
		ce && cmd_wr && !cmd_word[dcs_pkg::CW_VALID] |=> applied_cmd == $past(applied_cmd);
	endproperty
	a_ignore: assert property (p_ignore) else $error("invalid command word applied");

	property p_trst;
		// a pulse only outlives its cycle when enable froze it
		s_take_rise |=> trip_reset ##1 (!trip_reset || !$past(ce));
	endproperty
	a_trst: assert property (p_trst) else $error("trip reset not a single pulse");

	property p_trst_sd;
		trip_reset |-> status_word[6];
	endproperty
	a_trst_sd: assert property (p_trst_sd) else $error("start disable not set by trip reset");

	property p_release;
		s_release |=> !status_word[6];
	endproperty
	a_release: assert property (p_release) else $error("start disable not released");

	property p_reject;
		ce && cfg_wr_serial && !local_cfg.wr |=> cfg_rejected && node_addr == $past(node_addr);
	endproperty
	a_reject: assert property (p_reject) else $error("serial settings write not refused");

endmodule : dcs_core

`default_nettype wire

// ### sim/dcs_master_model.sv
// serial master stand-in: sends command, reference and settings strobes
// assumes callers enter its tasks from a rising-edge-aligned process
`timescale 1ns/1ps
`default_nettype none

module dcs_master_model (
	// clock
	input wire logic clock,
	// strobes and words toward the drive
	output logic cmd_wr,
	output logic [15:0] cmd_word,
	output logic ref_wr,
	output logic [15:0] ref_word,
	output logic cfg_wr_serial
);
	// ====
	// idle lines; released words show the inverse so stale data never matches
	initial begin
		cmd_wr = 1'b0;
		cmd_word = 16'hffff;
		ref_wr = 1'b0;
		ref_word = 16'hffff;
		cfg_wr_serial = 1'b0;
	end

	// caller sets bit 10; word held for exactly one edge
	task automatic send_cmd(input logic [15:0] w, input int gap);
		repeat (gap) @(posedge clock);
		@(posedge clock);
		cmd_wr <= 1'b1;
		cmd_word <= w;
		@(posedge clock);
		cmd_wr <= 1'b0;
		cmd_word <= ~w;
	endtask : send_cmd

	// signed word, negative values in two's complement
	task automatic send_ref(input logic [15:0] r, input int gap);
		repeat (gap) @(posedge clock);
		@(posedge clock);
		ref_wr <= 1'b1;
		ref_word <= r;
		@(posedge clock);
		ref_wr <= 1'b0;
		ref_word <= ~r;
	endtask : send_ref

	// node settings attempt over the link; the drive must refuse it
	task automatic send_cfg(input int gap);
		repeat (gap) @(posedge clock);
		@(posedge clock);
		cfg_wr_serial <= 1'b1;
		@(posedge clock);
		cfg_wr_serial <= 1'b0;
	endtask : send_cfg
endmodule : dcs_master_model
`default_nettype wire

// ### sim/drive_command_status_profile_tb.sv
// self-checking bench for the drive command/status interpreter
// assumes dcs_pkg, dcs_core and dcs_master_model are compiled first
`timescale 1ns/1ps
`default_nettype none

module drive_command_status_profile_tb;
	// ====
	// result kinds: words below K_REV, flags from it on
	localparam int K_ST = 0;
	localparam int K_CMD = 1;
	localparam int K_TGT = 2;
	localparam int K_FRQ = 3;
	localparam int K_ADR = 4;
	localparam int K_BD = 5;
	localparam int K_SEL = 6;
	localparam int K_REV = 7;
	localparam int K_CST = 8;
	localparam int K_REJ = 9;
	localparam int K_TRP = 10;
	typedef struct {int kind; logic [15:0] val; int due;} dcs_note_t;
	// inputs toward the design
	logic clock, reset, ce, coast_in_n, freq_rev, cmd_wr, ref_wr, cfg_wr_serial;
	logic [15:0] cmd_word, ref_word, freq_now, ref_min, ref_max, flim_lo, flim_hi, catch_amt, jog1_freq, jog2_freq;
	dcs_pkg::dcs_local_cfg_t local_cfg;
	dcs_pkg::dcs_proto_t proto;
	dcs_pkg::dcs_drv_st_t drv;
	// design answers
	logic [15:0] status_word, freq_word, applied_cmd, target_freq;
	logic cfg_rejected, reverse, coast_active, trip_reset;
	logic [7:0] node_addr;
	dcs_pkg::dcs_baud_t line_speed;
	dcs_pkg::dcs_src_t coast_sel;
	// bookkeeping and expected state
	dcs_note_t q[$];
	int ncyc = 0;
	int checks = 0;
	int bad_count = 0;
	integer seed = 66;
	logic [15:0] cw_e = 16'h0000;
	logic [15:0] sref_e = 16'h0000;
	logic sd_e = 1'b1;
	logic [7:0] addr_e = 8'h01;
	logic [1:0] csel_e = 2'h3;
	logic [15:0] rst_v [11] = '{16'h0070, 16'h0, 16'h0, 16'h0, 16'h1, 16'h5, 16'h3, 16'h0, 16'h1, 16'h0, 16'h0};
	logic [15:0] jw [6] = '{16'h0c8f, 16'h148f, 16'h1c8f, 16'h058f, 16'h068f, 16'h078f};
	logic [15:0] fx [5][3] = '{'{16'h19, 16'h0, 16'h2000}, '{16'h0, 16'h0, 16'h0}, '{16'h32, 16'h0, 16'h4000},
		'{16'h19, 16'h1, 16'he000}, '{16'h64, 16'h0, 16'h7fff}};
	logic [9:0] at [7] = '{10'h000, 10'h100, 10'h1ff, 10'h3f8, 10'h3f7, 10'h0f8, 10'h101};

	dcs_core DUT (
		.clock, .reset, .ce, .cmd_wr, .cmd_word, .ref_wr, .ref_word, .cfg_wr_serial,
		.local_cfg, .proto, .drv, .coast_in_n, .freq_now, .freq_rev, .ref_min, .ref_max,
		.flim_lo, .flim_hi, .catch_amt, .jog1_freq, .jog2_freq, .status_word, .freq_word,
		.cfg_rejected, .applied_cmd, .target_freq, .reverse, .coast_active, .trip_reset,
		.node_addr, .line_speed, .coast_sel
	);
	dcs_master_model MST (.clock, .cmd_wr, .cmd_word, .ref_wr, .ref_word, .cfg_wr_serial);

	always #20 clock = ~clock;

	// ====
	// expectation helpers
	function automatic logic coast_e();
		case (csel_e)
			2'h0: return ~coast_in_n;
			2'h1: return ~cw_e[3];
			2'h2: return ~coast_in_n & ~cw_e[3];
			default: return ~coast_in_n | ~cw_e[3];
		endcase
	endfunction : coast_e

	// state word from held command, start-disable and drive flags
	function automatic logic [15:0] st_exp();
		return {drv.therm_warn, drv.cur_limit, drv.volt_warn, 1'b0, drv.running, drv.freq_ok, drv.serial_ok,
			drv.at_ref, drv.warning, sd_e, ~cw_e[2], ~cw_e[1], drv.trip, &cw_e[3:0] & ~drv.trip,
			drv.drive_ready & coast_e(), &cw_e[2:0] & drv.drive_ready};
	endfunction : st_exp

	// jog 1 beats jog 2; slow-down beats catch-up; 16384 maps to the top
	function automatic logic [15:0] tgt_exp();
		int r;
		if (cw_e[8])
			return jog1_freq;
		if (cw_e[9])
			return jog2_freq;
		r = int'($signed(sref_e));
		if (cw_e[11])
			r = r - int'(catch_amt);
		else if (cw_e[12])
			r = r + int'(catch_amt);
		if (r < 0)
			r = -r;
		return 16'(int'(ref_min) + ((int'(ref_max - ref_min) * r) >>> 14));
	endfunction : tgt_exp

	function automatic logic [15:0] pick(input int k);
		case (k)
			K_ST: return status_word;
			K_CMD: return applied_cmd;
			K_TGT: return target_freq;
			K_FRQ: return freq_word;
			K_ADR: return {8'h00, node_addr};
			K_BD: return {13'h0, line_speed};
			K_SEL: return {14'h0, coast_sel};
			K_REV: return {15'h0, reverse};
			K_CST: return {15'h0, coast_active};
			K_REJ: return {15'h0, cfg_rejected};
			default: return {15'h0, trip_reset};
		endcase
	endfunction : pick

	task automatic cmp_word(input int k, input logic [15:0] got, input logic [15:0] exp);
		checks = checks + 1;
		if (got !== exp) begin
			bad_count = bad_count + 1;
			$display("[ERR] %0t kind %0d got %h exp %h", $time, k, got, exp);
		end
	endtask : cmp_word

	task automatic cmp_bit(input int k, input logic got, input logic exp);
		checks = checks + 1;
		if (got !== exp) begin
			bad_count = bad_count + 1;
			$display("[ERR] %0t flag %0d got %b exp %b", $time, k, got, exp);
		end
	endtask : cmp_bit

	task automatic note(input int k, input logic [15:0] v, input int lat);
		q.push_back('{k, v, ncyc + lat});
	endtask : note

	// watcher: outputs settle by the falling edge; oldest note first
	always @(negedge clock) begin
		dcs_note_t n;
		logic [15:0] w;
		ncyc = ncyc + 1;
		while (q.size() > 0 && q[0].due <= ncyc) begin
			n = q.pop_front();
			w = pick(n.kind);
			if (n.kind >= K_REV)
				cmp_bit(n.kind, w[0], n.val[0]); // per note
			else
				cmp_word(n.kind, w, n.val); // per note
		end
	end

	// ====
	// drivers; each returns on the edge that took the request
	task automatic do_cmd(input logic [15:0] w);
		logic [15:0] p;
		logic ev;
		p = cw_e;
		ev = 1'b0;
		drv <= dcs_pkg::dcs_drv_st_t'(10'($random(seed)));
		MST.send_cmd(w, 0);
		if (w[10]) begin
			cw_e = w;
			ev = w[7] & ~p[7];
			if (ev | (p[1] & ~w[1]) | (p[2] & ~w[2]))
				sd_e = 1'b1;
			else if (~w[0] & w[1] & w[2])
				sd_e = 1'b0;
		end
		note(K_ST, st_exp(), 1);
		note(K_CMD, cw_e, 1);
		note(K_CST, {15'h0, coast_e()}, 1);
		note(K_TRP, {15'h0, ev}, 1);
		note(K_TRP, 16'h0, 2);
	endtask : do_cmd

	task automatic do_ref(input logic [15:0] r);
		MST.send_ref(r, 1);
		sref_e = r;
		note(K_TGT, tgt_exp(), 2);
		note(K_REV, {15'h0, r[15]}, 2);
	endtask : do_ref

	// local panel store; illegal fields keep their old value
	task automatic lcfg(input logic [7:0] a, input logic [2:0] b, input logic [1:0] s);
		@(posedge clock);
		local_cfg <= '{1'b1, a, dcs_pkg::dcs_baud_t'(b), dcs_pkg::dcs_src_t'(s)};
		@(posedge clock);
		local_cfg.wr <= 1'b0;
		if (a >= ((proto == dcs_pkg::DCS_PR_NATIVE) ? 8'h00 : 8'h01) && a <= ((proto == dcs_pkg::DCS_PR_BLDG) ? 8'hff : 8'hf7))
			addr_e = a;
		csel_e = s;
		note(K_ADR, {8'h00, addr_e}, 1);
		note(K_BD, (b <= 3'h5) ? {13'h0, b} : 16'h5, 1);
		note(K_SEL, {14'h0, s}, 1);
	endtask : lcfg

	task automatic tally_and_finish();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : tally_and_finish

	// watchdog: the run needs about 130 cycles
	initial begin
		#80000;
		bad_count = bad_count + 1;
		$display("[ERR] %0t watchdog expired", $time);
		tally_and_finish();
	end

	// ====
	// main sequence
	initial begin
		clock = 1'b0;
		reset = 1'b1;
		ce = 1'b1;
		coast_in_n = 1'b1;
		freq_rev = 1'b0;
		freq_now = 16'h0000;
		ref_min = 16'h0100;
		ref_max = 16'h2100;
		flim_lo = 16'h0000;
		flim_hi = 16'h0032;
		catch_amt = 16'h0000;
		jog1_freq = 16'h0000;
		jog2_freq = 16'h0000;
		proto = dcs_pkg::DCS_PR_NATIVE;
		drv = '0;
		local_cfg = '{1'b0, 8'h01, dcs_pkg::DCS_BD_9600, dcs_pkg::DCS_SRC_OR};
		foreach (rst_v[i])
			note(i, rst_v[i], 1);
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		do_cmd(16'h007f);
		do_cmd(16'h0406);
		do_cmd(16'h040f);
		do_cmd(16'h040d);
		do_cmd(16'h0406);
		do_cmd(16'h040b);
		do_cmd(16'h0406);
		do_cmd(16'h048f);
		do_cmd(16'h048f);
		do_ref(16'h2000);
		do_ref(16'he000);
		do_ref(16'h2000);
		foreach (jw[i]) begin
			catch_amt <= 16'($random(seed)) & 16'h0ffe;
			jog1_freq <= 16'($random(seed));
			jog2_freq <= 16'($random(seed));
			do_cmd(jw[i]);
			@(posedge clock);
			note(K_TGT, tgt_exp(), 1);
		end
		foreach (fx[i]) begin
			@(posedge clock);
			freq_now <= fx[i][0];
			freq_rev <= fx[i][1][0];
			note(K_FRQ, fx[i][2], 2);
		end
		for (int s = 0; s < 4; s++) begin
			lcfg(addr_e, 3'h5, 2'(s));
			for (int v = 0; v < 4; v++) begin
				coast_in_n <= v[1];
				do_cmd(v[0] ? 16'h048f : 16'h0487);
			end
		end
		foreach (at[i]) begin
			@(posedge clock);
			proto <= dcs_pkg::dcs_proto_t'(at[i][9:8]);
			lcfg(at[i][7:0], 3'(i), 2'h3);
		end
		MST.send_cfg(0);
		note(K_REJ, 16'h0001, 1);
		note(K_REJ, 16'h0000, 2);
		note(K_ADR, {8'h00, addr_e}, 2);
		repeat (4) @(posedge clock);
		// enable low: a valid word offered now must not land
		ce <= 1'b0;
		MST.send_cmd(16'h0406, 0);
		note(K_CMD, cw_e, 1);
		ce <= 1'b1;
		// release from a lock whose previous word kept on2/on3 high
		do_cmd(16'h0406);
		repeat (4) @(posedge clock);
		tally_and_finish();
	end
endmodule : drive_command_status_profile_tb
`default_nettype wire
